// File: verilog/trop_port.sv
// Operation
// [R1] A selected trigger copies buffered data into the output latch.
// [R2] Each nibble is chosen separately as triggered output or plain port.
// [R3] Two independent 4-bit channels, or one 8-bit channel.
// [R4] Triggers: first compare match, second compare match, external edge.
// [R5] Two-channel mode: each buffer write loads only its own nibble.
// [R6] Byte mode: a write to either buffer loads both nibbles.
// [R7] Buffer reads return the other nibble in the upper four bits.
// [R8] Control register clears to zero on reset.
// [R9] Software writes zero into reserved control bits.
// [R10] Nibble mode: first match moves high, second (or edge) moves low.
// [R11] Byte mode: second match (or edge) moves all eight bits.
// [R12] Latch loads on the clock edge of the trigger, then drives pins.
// [R13] Control register is eight bits, read and written as a byte.
// [R14] Plain-port nibbles ignore triggers; only port writes change them.
`timescale 1ns/1ps

module trop_port #(
  parameter bit VALID_EDGE_RISING = 1'b1
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic [trop_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [trop_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [trop_pkg::DATA_W-1:0]   avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          compare_match_first,
  input  wire logic                          compare_match_second,
  input  wire logic                          external_edge_trigger,
  output logic      [trop_pkg::BYTE_W-1:0]   triggered_output_port
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  trop_pkg::trop_bus_e               bus_state;
  trop_pkg::trop_bus_e               next_bus_state;
  logic [trop_pkg::DATA_W-1:0]       rdata_r;
  logic [trop_pkg::DATA_W-1:0]       next_rdata;
  logic [trop_pkg::BYTE_W-1:0]       trigger_output_control;
  logic [trop_pkg::BYTE_W-1:0]       next_control;
  logic [trop_pkg::STAT_W-1:0]       transfer_status;
  logic [trop_pkg::STAT_W-1:0]       next_status;
  logic                              bus_req;
  logic                              wr_fire;
  logic [trop_pkg::IDX_W-1:0]        reg_idx;
  logic [trop_pkg::BYTE_W-1:0]       wbyte;
  logic                              hit_low;
  logic                              hit_high;
  logic                              hit_ctrl;
  logic                              hit_latch;
  logic                              hit_status;
  logic                              ext_edge;
  logic                              ext_gated;
  logic                              byte_mode;
  logic                              low_nibble_rt_select;
  logic                              high_nibble_rt_select;
  logic                              external_trigger_select;
  logic [trop_pkg::BYTE_W-1:0]       port_output_latch;
  logic [trop_pkg::BYTE_W-1:0]       rd_byte;

  trop_nibble_if low_if ();
  trop_nibble_if high_if ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Only byte lane 0 carries data; upper lanes read zero
  assign reg_idx    = avs_address[trop_pkg::ADDR_W-1:2];
  assign wbyte      = avs_writedata[trop_pkg::BYTE_W-1:0];
  assign bus_req    = avs_read | avs_write;
  assign hit_low    = (reg_idx == trop_pkg::IDX_BUF_LOW);
  assign hit_high   = (reg_idx == trop_pkg::IDX_BUF_HIGH);
  assign hit_ctrl   = (reg_idx == trop_pkg::IDX_CTRL);
  assign hit_latch  = (reg_idx == trop_pkg::IDX_LATCH);
  assign hit_status = (reg_idx == trop_pkg::IDX_STATUS);

  // Write lands only at the edge where waitrequest is low
  assign wr_fire = (bus_state == trop_pkg::TROP_BUS_ANSWER) & avs_write
                 & avs_byteenable[0];

  // ----------------------------------------------------------------
  // Bus handshake: one wait state per access
  // ----------------------------------------------------------------
  assign avs_waitrequest = bus_req & (bus_state == trop_pkg::TROP_BUS_IDLE);

  always_comb begin
    next_bus_state = bus_state;
    next_rdata     = rdata_r;
    unique case (bus_state)
      trop_pkg::TROP_BUS_IDLE: begin
        if (bus_req) begin
          next_bus_state = trop_pkg::TROP_BUS_ANSWER;
          next_rdata     = {{(trop_pkg::DATA_W-trop_pkg::BYTE_W){1'b0}},
                            rd_byte};
        end
      end
      trop_pkg::TROP_BUS_ANSWER: begin
        next_bus_state = trop_pkg::TROP_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_state <= trop_pkg::TROP_BUS_IDLE;
      rdata_r   <= '0;
    end else begin
      bus_state <= next_bus_state;
      rdata_r   <= next_rdata;
    end
  end

  assign avs_readdata = rdata_r;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = '0;
    if (hit_low) begin
      rd_byte = {high_if.buf_q, low_if.buf_q};                 // [R7]
    end else if (hit_high) begin
      rd_byte = {low_if.buf_q, high_if.buf_q};                 // [R7]
    end else if (hit_ctrl) begin
      rd_byte = trigger_output_control;                         // [R13]
    end else if (hit_latch) begin
      rd_byte = port_output_latch;
    end else if (hit_status) begin
      rd_byte = {{(trop_pkg::BYTE_W-trop_pkg::STAT_W){1'b0}},
                 transfer_status};
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Reserved bits are not stored, so they read zero whatever is written
  always_comb begin
    next_control = trigger_output_control;
    if (wr_fire && hit_ctrl) begin
      next_control = wbyte & trop_pkg::CTRL_WMASK;              // [R13] [R9]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trigger_output_control <= trop_pkg::CTRL_RESET;           // [R8]
    end else begin
      trigger_output_control <= next_control;
    end
  end

  assign external_trigger_select =
    trigger_output_control[trop_pkg::CTRL_EXT_SEL];
  assign byte_mode             = trigger_output_control[trop_pkg::CTRL_BYTE];
  assign low_nibble_rt_select  = trigger_output_control[trop_pkg::CTRL_LOW_RT];
  assign high_nibble_rt_select =
    trigger_output_control[trop_pkg::CTRL_HIGH_RT];

  // ----------------------------------------------------------------
  // External edge input
  // ----------------------------------------------------------------
  trop_edge_sync #(
    .VALID_EDGE_RISING (VALID_EDGE_RISING)
  ) u_edge (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .pin_in     (external_edge_trigger),
    .edge_pulse (ext_edge)                                      // [R4]
  );

  assign ext_gated = ext_edge & external_trigger_select;

  // ----------------------------------------------------------------
  // Trigger routing
  // ----------------------------------------------------------------
  // Compare matches come from the timer on this clock: no synchroniser
  always_comb begin
    if (byte_mode) begin
      low_if.trig  = compare_match_second | ext_gated;          // [R11] [R3]
      high_if.trig = compare_match_second | ext_gated;          // [R11]
    end else begin
      low_if.trig  = compare_match_second | ext_gated;          // [R10]
      high_if.trig = compare_match_first;                       // [R10] [R4]
    end
  end

  assign low_if.rt_mode  = low_nibble_rt_select;                // [R2]
  assign high_if.rt_mode = high_nibble_rt_select;               // [R2]

  // ----------------------------------------------------------------
  // Buffer and direct port writes
  // ----------------------------------------------------------------
  always_comb begin
    low_if.buf_we  = 1'b0;
    high_if.buf_we = 1'b0;
    low_if.buf_wd  = wbyte[trop_pkg::NIB_W-1:0];
    high_if.buf_wd = wbyte[trop_pkg::BYTE_W-1:trop_pkg::NIB_W];
    if (wr_fire && (hit_low || hit_high)) begin
      if (byte_mode) begin
        low_if.buf_we  = 1'b1;                                  // [R6]
        high_if.buf_we = 1'b1;                                  // [R6]
      end else begin
        low_if.buf_we  = hit_low;                               // [R5]
        high_if.buf_we = hit_high;                              // [R5]
      end
    end
  end

  // Port writes reach only the nibbles in plain port mode
  assign low_if.port_we  = wr_fire & hit_latch;                 // [R14]
  assign high_if.port_we = wr_fire & hit_latch;                 // [R14]
  assign low_if.port_wd  = wbyte[trop_pkg::NIB_W-1:0];
  assign high_if.port_wd = wbyte[trop_pkg::BYTE_W-1:trop_pkg::NIB_W];

  trop_nibble u_low (
    .sys_clk (sys_clk),
    .rst     (rst),
    .nif     (low_if)
  );

  trop_nibble u_high (
    .sys_clk (sys_clk),
    .rst     (rst),
    .nif     (high_if)
  );

  assign port_output_latch     = {high_if.latch_q, low_if.latch_q};
  assign triggered_output_port = port_output_latch;             // [R12]

  // ----------------------------------------------------------------
  // Transfer status, write one to clear
  // ----------------------------------------------------------------
  // A new event in the clearing cycle wins over the clear
  always_comb begin
    next_status = transfer_status;
    if (wr_fire && hit_status) begin
      next_status = transfer_status & ~wbyte[trop_pkg::STAT_W-1:0];
    end
    if (high_if.moved) begin
      next_status[trop_pkg::STAT_HIGH] = 1'b1;
    end
    if (low_if.moved) begin
      next_status[trop_pkg::STAT_LOW] = 1'b1;
    end
    if (ext_edge) begin
      next_status[trop_pkg::STAT_EXT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      transfer_status <= trop_pkg::STAT_RESET;
    end else begin
      transfer_status <= next_status;
    end
  end

endmodule : trop_port

// File: include/trop_pkg.sv
package trop_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 18;
  localparam int          DATA_W       = 32;
  localparam int          IDX_W        = 16;
  localparam int          NIB_W        = 4;
  localparam int          BYTE_W       = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_BUF_LOW  = 16'hff4a;
  localparam logic [15:0] IDX_BUF_HIGH = 16'hff4b;
  localparam logic [15:0] IDX_CTRL     = 16'hff4c;
  localparam logic [15:0] IDX_LATCH    = 16'hff4d;
  localparam logic [15:0] IDX_STATUS   = 16'hff4e;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int          CTRL_EXT_SEL  = 0;
  localparam int          CTRL_BYTE     = 3;
  localparam int          CTRL_LOW_RT   = 4;
  localparam int          CTRL_HIGH_RT  = 7;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_WMASK    = 8'h99;

  // ----------------------------------------------------------------
  // Transfer status fields (write one to clear)
  // ----------------------------------------------------------------
  localparam int          STAT_HIGH     = 0;
  localparam int          STAT_LOW      = 1;
  localparam int          STAT_EXT      = 2;
  localparam int          STAT_W        = 3;
  localparam logic [2:0]  STAT_RESET    = 3'h0;

  localparam logic [3:0]  NIB_RESET     = 4'h0;

  typedef enum {
    TROP_BUS_IDLE,
    TROP_BUS_ANSWER
  } trop_bus_e;

endpackage : trop_pkg

// File: include/trop_nibble_if.sv
`timescale 1ns/1ps

interface trop_nibble_if;
  logic                        buf_we;
  logic [trop_pkg::NIB_W-1:0]  buf_wd;
  logic                        port_we;
  logic [trop_pkg::NIB_W-1:0]  port_wd;
  logic                        trig;
  logic                        rt_mode;
  logic [trop_pkg::NIB_W-1:0]  buf_q;
  logic [trop_pkg::NIB_W-1:0]  latch_q;
  logic                        moved;

  modport ctl (
    output buf_we,
    output buf_wd,
    output port_we,
    output port_wd,
    output trig,
    output rt_mode,
    input  buf_q,
    input  latch_q,
    input  moved
  );

  modport nib (
    input  buf_we,
    input  buf_wd,
    input  port_we,
    input  port_wd,
    input  trig,
    input  rt_mode,
    output buf_q,
    output latch_q,
    output moved
  );
endinterface : trop_nibble_if

// File: verilog/trop_edge_sync.sv
`timescale 1ns/1ps

module trop_edge_sync #(
  parameter bit VALID_EDGE_RISING = 1'b1
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      edge_pulse
);

  // ----------------------------------------------------------------
  // Synchroniser and edge detector
  // ----------------------------------------------------------------
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic pulse_q;
  logic next_sync_a;
  logic next_sync_b;
  logic next_sync_c;
  logic next_pulse;

  always_comb begin
    next_sync_a = pin_in;
    next_sync_b = sync_a;
    next_sync_c = sync_b;
    // The second and third stages feed the detector
    if (VALID_EDGE_RISING) begin
      next_pulse = sync_b & ~sync_c;
    end else begin
      next_pulse = ~sync_b & sync_c;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_a  <= 1'b0;
      sync_b  <= 1'b0;
      sync_c  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      sync_a  <= next_sync_a;
      sync_b  <= next_sync_b;
      sync_c  <= next_sync_c;
      pulse_q <= next_pulse;
    end
  end

  assign edge_pulse = pulse_q;

endmodule : trop_edge_sync

// File: verilog/trop_nibble.sv
`timescale 1ns/1ps

module trop_nibble (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  trop_nibble_if.nib  nif
);

  // ----------------------------------------------------------------
  // Buffer half and its output latch
  // ----------------------------------------------------------------
  logic [trop_pkg::NIB_W-1:0] buf_r;
  logic [trop_pkg::NIB_W-1:0] latch_r;
  logic                       moved_r;
  logic [trop_pkg::NIB_W-1:0] next_buf;
  logic [trop_pkg::NIB_W-1:0] next_latch;
  logic                       next_moved;

  always_comb begin
    next_buf   = buf_r;
    next_latch = latch_r;
    next_moved = 1'b0;
    if (nif.buf_we) begin
      next_buf = nif.buf_wd;
    end
    // Latch takes the old buffer when a write meets a trigger
    if (nif.rt_mode && nif.trig) begin
      next_latch = buf_r;          // [R1] [R12]
      next_moved = 1'b1;
    end else if (!nif.rt_mode && nif.port_we) begin
      next_latch = nif.port_wd;    // [R14]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      buf_r   <= trop_pkg::NIB_RESET;
      latch_r <= trop_pkg::NIB_RESET;
      moved_r <= 1'b0;
    end else begin
      buf_r   <= next_buf;
      latch_r <= next_latch;
      moved_r <= next_moved;
    end
  end

  assign nif.buf_q   = buf_r;
  assign nif.latch_q = latch_r;
  assign nif.moved   = moved_r;

endmodule : trop_nibble

// File: tb/trop_port_properties.sv
`timescale 1ns/1ps

module trop_port_checker #(
  parameter bit VALID_EDGE_RISING = 1'b1
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [17:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        compare_match_first,
  input wire logic        compare_match_second,
  input wire logic        external_edge_trigger,
  input wire logic [7:0]  triggered_output_port
);
  // ----------------------------------------------------------------
  // Shadow of the control register and both buffer nibbles
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [3:0] blo;
  logic [3:0] bhi;
  logic       ext_q;
  logic [2:0] ext_age;
  wire  logic [15:0] idx   = avs_address[17:2];
  wire  logic        wdone = avs_write & ~avs_waitrequest & avs_byteenable[0];
  // Pin edges take several edges to reach the latch
  wire  logic        quiet = ext_age[2];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl    <= 8'h00;
      blo     <= 4'h0;
      bhi     <= 4'h0;
      ext_q   <= 1'b0;
      ext_age <= 3'h7;
    end else begin
      ext_q   <= external_edge_trigger;
      if (ext_q != external_edge_trigger)
        ext_age <= 3'h0;
      else if (ext_age != 3'h7)
        ext_age <= ext_age + 3'h1;
      if (wdone && idx == trop_pkg::IDX_CTRL)
        ctrl <= avs_writedata[7:0] & trop_pkg::CTRL_WMASK;
      if (wdone && (idx == trop_pkg::IDX_BUF_LOW ||
                    (idx == trop_pkg::IDX_BUF_HIGH && ctrl[3])))
        blo <= avs_writedata[3:0];
      if (wdone && (idx == trop_pkg::IDX_BUF_HIGH ||
                    (idx == trop_pkg::IDX_BUF_LOW && ctrl[3])))
        bhi <= avs_writedata[7:4];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ext_edge;
    VALID_EDGE_RISING ? $rose(external_edge_trigger)
                      : $fell(external_edge_trigger);
  endsequence

  a_wait_one_state: assert property (s_req_wait |=> !avs_waitrequest)
    else $error("second wait state seen");
  a_wait_no_req: assert property
    (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_read_upper_zero: assert property
    (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_low_read_swap: assert property (avs_read && !avs_waitrequest &&
    idx == trop_pkg::IDX_BUF_LOW |-> avs_readdata[7:0] == {bhi, blo})
    else $error("low buffer read wrong");
  a_high_first_match: assert property (compare_match_first &&
    ctrl[7] && !ctrl[3] |=> triggered_output_port[7:4] == $past(bhi))
    else $error("high nibble not moved");
  a_low_second_match: assert property (compare_match_second &&
    ctrl[4] && !ctrl[3] |=> triggered_output_port[3:0] == $past(blo))
    else $error("low nibble not moved");
  a_byte_second_match: assert property (compare_match_second &&
    ctrl[3] && ctrl[7] && ctrl[4]
    |=> triggered_output_port == $past({bhi, blo}))
    else $error("byte transfer wrong");
  a_byte_first_quiet: assert property (compare_match_first &&
    !compare_match_second && ctrl[3] && !wdone && quiet
    |=> $stable(triggered_output_port))
    else $error("first match moved byte");
  a_plain_ignores: assert property ((compare_match_first ||
    compare_match_second) && !ctrl[7] && !wdone
    |=> $stable(triggered_output_port[7:4]))
    else $error("plain nibble followed trigger");
  a_ext_low_move: assert property (s_ext_edge ##0
    (ctrl[0] && ctrl[4] && !ctrl[3])
    |-> ##[3:5] triggered_output_port[3:0] == blo)
    else $error("edge did not move low nibble");
endmodule : trop_port_checker

bind trop_port trop_port_checker #(
  .VALID_EDGE_RISING(VALID_EDGE_RISING)
) u_chk (
  .sys_clk              (sys_clk),
  .rst                  (rst),
  .avs_address          (avs_address),
  .avs_read             (avs_read),
  .avs_write            (avs_write),
  .avs_writedata        (avs_writedata),
  .avs_byteenable       (avs_byteenable),
  .avs_readdata         (avs_readdata),
  .avs_waitrequest      (avs_waitrequest),
  .compare_match_first  (compare_match_first),
  .compare_match_second (compare_match_second),
  .external_edge_trigger(external_edge_trigger),
  .triggered_output_port(triggered_output_port)
);

// File: tb/trop_trigger_model.sv
`timescale 1ns/1ps

module trop_trigger_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic go_first,
  input  wire logic go_second,
  input  wire logic pin_req,
  output logic      compare_match_first,
  output logic      compare_match_second,
  output logic      external_edge_trigger
);
  // ----------------------------------------------------------------
  // Compare matches are single pulses; the pin is a plain level
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      compare_match_first   <= 1'b0;
      compare_match_second  <= 1'b0;
      external_edge_trigger <= 1'b0;
    end else begin
      compare_match_first   <= go_first;
      compare_match_second  <= go_second;
      external_edge_trigger <= pin_req;
    end
  end
endmodule : trop_trigger_model

// File: tb/trop_port_test.sv
`timescale 1ns/1ps

module trop_port_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        sys_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic        go_first, go_second, pin_req, cm1, cm2, ext;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable, lo, hi;
  logic [7:0]  port, pv, d;
  logic [31:0] exp_q[$];
  int          miscompares, compares, cycles, seed;

  trop_port dut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .compare_match_first(cm1), .compare_match_second(cm2),
    .external_edge_trigger(ext), .triggered_output_port(port));
  trop_trigger_model u_trig (
    .sys_clk(sys_clk), .rst(rst), .go_first(go_first),
    .go_second(go_second), .pin_req(pin_req),
    .compare_match_first(cm1), .compare_match_second(cm2),
    .external_edge_trigger(ext));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task bus(input logic w, input logic [15:0] i, input logic [7:0] v,
           input logic [3:0] be);
    @(posedge sys_clk);
    avs_read       <= !w;
    avs_write      <= w;
    avs_address    <= {i, 2'b00};
    avs_writedata  <= {24'h0, v};
    avs_byteenable <= be;
    // Waitrequest is seen as it stood just before each rising edge
    do @(posedge sys_clk);
    while (avs_waitrequest);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task wr(input logic [15:0] i, input logic [7:0] v);
    bus(1'b1, i, v, 4'h1);
  endtask : wr

  task rd(input logic [15:0] i, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, i, 8'h00, 4'h1);
  endtask : rd

  task trig(input logic f, input logic s);
    @(posedge sys_clk);
    go_first  <= f;
    go_second <= s;
    @(posedge sys_clk);
    go_first  <= 1'b0;
    go_second <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : trig

  task edge_pin();
    @(posedge sys_clk);
    pin_req <= ~pin_req;
    repeat (8) @(posedge sys_clk);
  endtask : edge_pin

  task cport(input logic [7:0] e);
    @(negedge sys_clk);
    check("port", {24'h0, port}, {24'h0, e});
  endtask : cport

  always @(negedge sys_clk)
    if (avs_read && !avs_waitrequest)
      check("readdata", avs_readdata, exp_q.pop_front());

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 35116;
    {rst, go_first, go_second, pin_req} = 4'hf;
    {go_first, go_second, pin_req} = 3'h0;
    {avs_read, avs_write, avs_address} = '0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(trop_pkg::IDX_CTRL, 32'h0);
    rd(trop_pkg::IDX_LATCH, 32'h0);
    rd(16'h0000, 32'h0);
    wr(trop_pkg::IDX_CTRL, 8'hff);
    rd(trop_pkg::IDX_CTRL, 32'h99);
    bus(1'b1, trop_pkg::IDX_CTRL, 8'h00, 4'h0);
    rd(trop_pkg::IDX_CTRL, 32'h99);
    $display("test reset_ctrl done");
    wr(trop_pkg::IDX_CTRL, 8'h00);
    d = 8'($random(seed));
    wr(trop_pkg::IDX_LATCH, d);
    wr(trop_pkg::IDX_BUF_LOW, ~d);
    wr(trop_pkg::IDX_BUF_HIGH, ~d);
    {hi, lo} = ~d;
    pv = d;
    trig(1'b1, 1'b1);
    cport(pv);
    $display("test plain_port done");
    wr(trop_pkg::IDX_CTRL, 8'h90);
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      wr(trop_pkg::IDX_BUF_LOW, d);
      lo = d[3:0];
      rd(trop_pkg::IDX_BUF_HIGH, {24'h0, lo, hi});
      d = 8'($random(seed));
      wr(trop_pkg::IDX_BUF_HIGH, d);
      hi = d[7:4];
      rd(trop_pkg::IDX_BUF_LOW, {24'h0, hi, lo});
      trig(1'b1, 1'b0);
      pv[7:4] = hi;
      cport(pv);
      trig(1'b0, 1'b1);
      pv[3:0] = lo;
      cport(pv);
    end
    $display("test nibble_mode done");
    wr(trop_pkg::IDX_CTRL, 8'h10);
    d = 8'($random(seed));
    wr(trop_pkg::IDX_LATCH, d);
    pv[7:4] = d[7:4];
    cport(pv);
    wr(trop_pkg::IDX_BUF_LOW, ~d);
    lo = ~d[3:0];
    trig(1'b1, 1'b1);
    pv[3:0] = lo;
    cport(pv);
    $display("test mixed_mode done");
    wr(trop_pkg::IDX_CTRL, 8'h90);
    wr(trop_pkg::IDX_BUF_LOW, {4'h0, ~pv[3:0]});
    lo = ~pv[3:0];
    edge_pin();
    cport(pv);
    wr(trop_pkg::IDX_CTRL, 8'h91);
    edge_pin();
    cport(pv);
    edge_pin();
    pv[3:0] = lo;
    cport(pv);
    $display("test ext_edge done");
    rd(trop_pkg::IDX_STATUS, 32'h7);
    wr(trop_pkg::IDX_STATUS, 8'h07);
    rd(trop_pkg::IDX_STATUS, 32'h0);
    wr(trop_pkg::IDX_CTRL, 8'h98);
    for (int k = 0; k < 3; k++) begin
      d = 8'($random(seed));
      wr(k[0] ? trop_pkg::IDX_BUF_HIGH : trop_pkg::IDX_BUF_LOW, d);
      rd(trop_pkg::IDX_BUF_HIGH, {24'h0, d[3:0], d[7:4]});
      trig(1'b1, 1'b0);
      cport(pv);
      trig(1'b0, 1'b1);
      pv = d;
      cport(pv);
    end
    wr(trop_pkg::IDX_CTRL, 8'h99);
    d = 8'($random(seed));
    wr(trop_pkg::IDX_BUF_LOW, d);
    edge_pin();
    cport(pv);
    edge_pin();
    pv = d;
    cport(pv);
    $display("test byte_mode done");
    end_sim();
  end
endmodule : trop_port_test
